// File: cpu_model.sv
// Purpose: CPU side model driving the timer I/O port
// Assumes: one access per strobe, an idle cycle between accesses
// Notes: strobes change just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module cpu_model
	import timer16_pkg::*;
(
	// Clock
	input wire logic mclk,
	// I/O port
	output var io_req_t io_req,
	input wire logic [7:0] io_rdata
);
	initial io_req = '0;

	task automatic wr(input logic [3:0] s, input logic [7:0] d);
		@(posedge mclk);
		#1 io_req = '{sel: s, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge mclk);
		#1 io_req = '0;
	endtask

	task automatic rd(input logic [3:0] s, output logic [7:0] d);
		@(posedge mclk);
		#1 io_req = '{sel: s, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge mclk);
		#1 io_req = '0;
		d = io_rdata;
	endtask
endmodule
`default_nettype wire

// File: timer16_checker.sv
// Purpose: port checks of the timer counter and capture block
// Assumes: control state tracked from bus writes
// Notes: bound to the design top
`timescale 1ns/1ps
`default_nettype none
module timer16_checker
	import timer16_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Bus and events
	input wire io_req_t io_req,
	input wire logic [7:0] io_rdata,
	input wire logic capture_irq_ack,
	input wire logic overflow_irq_ack,
	input wire logic capture_irq,
	input wire logic overflow_irq,
	input wire logic [15:0] timer_count,
	input wire logic count_at_bottom
);
	logic [2:0] src_r;
	logic [3:0] mode_r;
	logic oie_r;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			src_r <= CS_STOP;
			mode_r <= WGM_NORMAL;
			oie_r <= 1'b0;
		end else if (io_req.wr) begin
			if (io_req.sel == SEL_CTRL_A)
				mode_r[1:0] <= io_req.wdata[1:0];
			if (io_req.sel == SEL_CTRL_B) begin
				mode_r[3:2] <= io_req.wdata[4:3];
				src_r <= io_req.wdata[2:0];
			end
			if (io_req.sel == SEL_IRQ_EN)
				oie_r <= io_req.wdata[B_OVF_FLAG];
		end
	end

	write_pair_a: assert property (
		io_req.wr && io_req.sel == SEL_CNT_L && $past(io_req.wr, 2) &&
		$past(io_req.sel, 2) == SEL_CNT_H |=>
		timer_count == {$past(io_req.wdata, 3), $past(io_req.wdata)})
		else $error("counter write lost");
	read_pair_a: assert property (
		io_req.rd && io_req.sel == SEL_CNT_H && $past(io_req.rd, 2) &&
		$past(io_req.sel, 2) == SEL_CNT_L |=>
		io_rdata == $past(timer_count[15:8], 3))
		else $error("counter high read wrong");
	stopped_a: assert property (
		src_r == CS_STOP && !io_req.wr |=> $stable(timer_count))
		else $error("stopped counter moved");
	count_up_a: assert property (
		src_r == CS_CLK && mode_r == WGM_NORMAL && !io_req.wr |=>
		timer_count == $past(timer_count) + CNT_ONE)
		else $error("counter did not step");
	ovf_set_a: assert property (
		src_r == CS_CLK && mode_r == WGM_NORMAL && oie_r && !io_req.wr &&
		!overflow_irq_ack && timer_count == CNT_MAX |=> overflow_irq)
		else $error("overflow missed");
	bottom_flag_a: assert property (
		count_at_bottom == (timer_count == CNT_BOTTOM))
		else $error("bottom flag wrong");
	cap_ack_a: assert property (
		capture_irq && capture_irq_ack |=> !capture_irq)
		else $error("capture ack ignored");
	flag_write_a: assert property (
		io_req.wr && io_req.sel == SEL_FLAGS && capture_irq &&
		!capture_irq_ack |=> capture_irq == !$past(io_req.wdata[5]))
		else $error("capture flag write wrong");
endmodule
bind timer16_count_and_capture timer16_checker u_timer16_checker (
	.mclk, .rst_n, .io_req, .io_rdata, .capture_irq_ack, .overflow_irq_ack,
	.capture_irq, .overflow_irq, .timer_count, .count_at_bottom);
`default_nettype wire

// File: timer16_count_and_capture.sv
// Purpose: 16-bit up/down counter with input capture and noise filter
// Assumes: all inputs synchronous to mclk; prescaler taps are one-cycle pulses
// Notes: read data appears on io_rdata one cycle after the read strobe
// Operation
// - High-byte counter access uses shared latch.
// - Counter low read loads latch with high.
// - Selector zero stops counter, others pick tick.
// - Each tick clears, increments or decrements counter.
// - CPU accesses counter with or without ticks.
// - CPU counter write beats clear or count.
// - Four-bit mode field selects count sequence.
// - Overflow flag set per mode, raises interrupt when enabled.
// - Count strobe, direction, clear, top and bottom.
// - Matching edge copies counter into capture register.
// - Capture flag set with capture register update.
// - Enabled capture flag requests interrupt, acked clears.
// - Writing one clears capture flag, zero keeps.
// - Capture low read loads latch with high.
// - Capture register writable only in capture-top modes.
// - Trigger from pin, or comparator when selected.
// - Filter output changes after four equal samples.
// - Enabled filter adds four system clocks delay.
// - Capture input off in capture-top modes.
// - Top is fixed value, compare A or capture.
// - Low-byte write commits latch and low together.
`timescale 1ns/1ps
`default_nettype none
module timer16_count_and_capture
	import timer16_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// CPU I/O port
	input wire io_req_t io_req,
	output logic [7:0] io_rdata,
	// Tick sources
	input wire presc_t presc_tick,
	input wire logic ext_tick_pin,
	// Capture sources
	input wire logic capture_pin,
	input wire logic comparator_output,
	input wire logic comparator_capture_select,
	// Interrupts
	input wire logic capture_irq_ack,
	input wire logic overflow_irq_ack,
	output logic capture_irq,
	output logic overflow_irq,
	// Counter state for compare units
	output logic [15:0] timer_count,
	output logic count_at_top,
	output logic count_at_bottom
);

	state_t st_r;
	state_t st_nxt;

	logic [3:0] wgm;
	logic [2:0] cs;
	logic timer_tick;
	logic [15:0] top_val;
	logic dual_slope;
	logic ovf_at_top;
	logic cap_top_mode;
	logic cnt_step;
	logic cnt_up;
	logic cnt_clear;
	logic reach_top;
	logic reach_bottom;
	logic cap_src;
	logic filt_next;
	logic cap_event;
	logic wr_cnt;
	logic wr_cap;
	logic ovf_set;

	assign wgm = {st_r.ctrl_b[B_WGM_HI+1:B_WGM_HI], st_r.wgm_lo};
	assign cs = st_r.ctrl_b[2:0];

	// Tick selection
	always_comb begin
		case (cs)
			CS_STOP: timer_tick = 1'b0;
			CS_CLK: timer_tick = 1'b1;
			CS_DIV8: timer_tick = presc_tick.div8;
			CS_DIV64: timer_tick = presc_tick.div64;
			CS_DIV256: timer_tick = presc_tick.div256;
			CS_DIV1024: timer_tick = presc_tick.div1024;
			CS_EXT_FALL: timer_tick = st_r.ext_prev & ~ext_tick_pin;
			CS_EXT_RISE: timer_tick = ~st_r.ext_prev & ext_tick_pin;
			default: timer_tick = 1'b0;
		endcase
	end

	// Mode decode and top value
	always_comb begin
		dual_slope = 1'b0;
		ovf_at_top = 1'b0;
		cap_top_mode = 1'b0;
		top_val = CNT_MAX;
		case (wgm)
			WGM_PC8: begin
				dual_slope = 1'b1;
				top_val = TOP_8BIT;
			end
			WGM_PC9: begin
				dual_slope = 1'b1;
				top_val = TOP_9BIT;
			end
			WGM_PC10: begin
				dual_slope = 1'b1;
				top_val = TOP_10BIT;
			end
			WGM_CTC_A: top_val = st_r.cmpa;
			WGM_FAST8: begin
				ovf_at_top = 1'b1;
				top_val = TOP_8BIT;
			end
			WGM_FAST9: begin
				ovf_at_top = 1'b1;
				top_val = TOP_9BIT;
			end
			WGM_FAST10: begin
				ovf_at_top = 1'b1;
				top_val = TOP_10BIT;
			end
			WGM_PFC_CAP, WGM_PC_CAP: begin
				dual_slope = 1'b1;
				cap_top_mode = 1'b1;
				top_val = st_r.cap;
			end
			WGM_PFC_A, WGM_PC_A: begin
				dual_slope = 1'b1;
				top_val = st_r.cmpa;
			end
			WGM_CTC_CAP: begin
				cap_top_mode = 1'b1;
				top_val = st_r.cap;
			end
			WGM_FAST_CAP: begin
				ovf_at_top = 1'b1;
				cap_top_mode = 1'b1;
				top_val = st_r.cap;
			end
			WGM_FAST_A: begin
				ovf_at_top = 1'b1;
				top_val = st_r.cmpa;
			end
			// Reserved code: single slope to the counter maximum
			default: top_val = CNT_MAX;
		endcase
	end

	// Counter control strobes
	// Dual slope turns at or above top
	assign reach_top = (st_r.cnt >= top_val);
	assign reach_bottom = (st_r.cnt == CNT_BOTTOM);
	always_comb begin
		cnt_step = 1'b0;
		cnt_up = 1'b1;
		cnt_clear = 1'b0;
		ovf_set = 1'b0;
		if (timer_tick) begin
			if (dual_slope) begin
				cnt_step = 1'b1;
				if (st_r.dir == DIR_UP) begin
					cnt_up = ~reach_top;
				end else begin
					cnt_up = reach_bottom;
					ovf_set = reach_bottom;
				end
			// Single slope clears at top, except in normal mode
			end else if (reach_top && wgm != WGM_NORMAL) begin
				cnt_clear = 1'b1;
				ovf_set = ovf_at_top | (st_r.cnt == CNT_MAX);
			end else begin
				cnt_step = 1'b1;
				ovf_set = (st_r.cnt == CNT_MAX);
			end
		end
	end

	// Capture path
	assign cap_src = comparator_capture_select ? comparator_output
		: capture_pin;
	always_comb begin
		filt_next = st_r.filt_out;
		// Filter off: output follows the sampled input
		if (!st_r.ctrl_b[B_NF_EN]) begin
			filt_next = st_r.in_smp;
		end else if (&st_r.filt_sh) begin
			filt_next = 1'b1;
		end else if (~|st_r.filt_sh) begin
			filt_next = 1'b0;
		end
	end
	assign cap_event = ~cap_top_mode
		& (st_r.filt_out != st_r.edge_prev)
		& (st_r.filt_out == st_r.ctrl_b[B_EDGE_RISE]);

	assign wr_cnt = io_req.wr & (io_req.sel == SEL_CNT_L);
	assign wr_cap = io_req.wr & (io_req.sel == SEL_CAP_L) & cap_top_mode;

	// Next state
	always_comb begin
		st_nxt = st_r;
		// Last pin level, for external tick edges
		st_nxt.ext_prev = ext_tick_pin;

		// Counter
		// A CPU write drops the tick and its overflow
		if (wr_cnt) begin
			st_nxt.cnt = {st_r.temp, io_req.wdata};
		end else if (cnt_clear) begin
			st_nxt.cnt = CNT_BOTTOM;
		end else if (cnt_step) begin
			st_nxt.cnt = cnt_up ? st_r.cnt + CNT_ONE
				: st_r.cnt - CNT_ONE;
		end
		// Direction turns at top and bottom
		if (timer_tick && dual_slope && !wr_cnt) begin
			if (st_r.dir == DIR_UP && reach_top) begin
				st_nxt.dir = DIR_DOWN;
			end else if (st_r.dir == DIR_DOWN && reach_bottom) begin
				st_nxt.dir = DIR_UP;
			end
		end
		if (!dual_slope) begin
			st_nxt.dir = DIR_UP;
		end

		// Capture filter and edge detector
		st_nxt.in_smp = cap_src;
		st_nxt.filt_sh = {st_r.filt_sh[FILT_SAMPLES-2:0], st_r.in_smp};
		st_nxt.filt_out = filt_next;
		st_nxt.edge_prev = st_r.filt_out;
		if (cap_top_mode) begin
			// Frozen so that no false edge appears on leaving the mode
			st_nxt.in_smp = st_r.in_smp;
			st_nxt.filt_sh = st_r.filt_sh;
			st_nxt.filt_out = st_r.filt_out;
		end

		// Flags: hardware set wins over clear
		if ((io_req.wr && io_req.sel == SEL_FLAGS
			&& io_req.wdata[B_CAP_FLAG]) || capture_irq_ack) begin
			st_nxt.cap_flag = 1'b0;
		end
		if ((io_req.wr && io_req.sel == SEL_FLAGS
			&& io_req.wdata[B_OVF_FLAG]) || overflow_irq_ack) begin
			st_nxt.ovf_flag = 1'b0;
		end
		if (cap_event) begin
			st_nxt.cap = st_r.cnt;
			st_nxt.cap_flag = 1'b1;
		end
		if (ovf_set && !wr_cnt) begin
			st_nxt.ovf_flag = 1'b1;
		end

		// CPU writes
		if (io_req.wr) begin
			case (io_req.sel)
				SEL_CTRL_A: st_nxt.wgm_lo = io_req.wdata[1:0];
				SEL_CTRL_B: st_nxt.ctrl_b = io_req.wdata;
				SEL_CNT_H, SEL_CAP_H, SEL_CMPA_H: begin
					st_nxt.temp = io_req.wdata;
				end
				// Compare A is written directly, no double buffer
				SEL_CMPA_L: st_nxt.cmpa = {st_r.temp, io_req.wdata};
				SEL_IRQ_EN: begin
					st_nxt.cap_ie = io_req.wdata[B_CAP_FLAG];
					st_nxt.ovf_ie = io_req.wdata[B_OVF_FLAG];
				end
				default: st_nxt.temp = st_r.temp;
			endcase
		end
		if (wr_cap) begin
			st_nxt.cap = {st_r.temp, io_req.wdata};
		end

		// CPU reads
		// Read data is zero outside a read strobe
		st_nxt.rdata = 8'h00;
		if (io_req.rd) begin
			case (io_req.sel)
				SEL_CTRL_A: st_nxt.rdata = {6'h00, st_r.wgm_lo};
				SEL_CTRL_B: st_nxt.rdata = st_r.ctrl_b;
				SEL_CNT_L: begin
					st_nxt.rdata = st_r.cnt[7:0];
					st_nxt.temp = st_r.cnt[15:8];
				end
				SEL_CAP_L: begin
					st_nxt.rdata = st_r.cap[7:0];
					st_nxt.temp = st_r.cap[15:8];
				end
				SEL_CNT_H, SEL_CAP_H: st_nxt.rdata = st_r.temp;
				SEL_CMPA_L: st_nxt.rdata = st_r.cmpa[7:0];
				SEL_CMPA_H: st_nxt.rdata = st_r.cmpa[15:8];
				SEL_FLAGS: begin
					st_nxt.rdata[B_CAP_FLAG] = st_r.cap_flag;
					st_nxt.rdata[B_OVF_FLAG] = st_r.ovf_flag;
				end
				SEL_IRQ_EN: begin
					st_nxt.rdata[B_CAP_FLAG] = st_r.cap_ie;
					st_nxt.rdata[B_OVF_FLAG] = st_r.ovf_ie;
				end
				default: st_nxt.rdata = 8'h00;
			endcase
		end

		// Registered outputs
		// Interrupt lines follow the next flag state
		st_nxt.cap_irq = st_nxt.cap_flag & st_nxt.cap_ie;
		st_nxt.ovf_irq = st_nxt.ovf_flag & st_nxt.ovf_ie;
		st_nxt.at_top = (st_nxt.cnt == top_val);
		st_nxt.at_bottom = (st_nxt.cnt == CNT_BOTTOM);
	end

	// Synchronous reset: stopped, normal mode, at bottom
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.dir <= DIR_UP;
			st_r.at_bottom <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign io_rdata = st_r.rdata;
	assign capture_irq = st_r.cap_irq;
	assign overflow_irq = st_r.ovf_irq;
	assign timer_count = st_r.cnt;
	assign count_at_top = st_r.at_top;
	assign count_at_bottom = st_r.at_bottom;

endmodule
`default_nettype wire

// File: timer16_count_and_capture_test.sv
// Purpose: self-checking bench of the timer counter and capture block
// Assumes: prescaler taps and external tick idle except in t_src
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module timer16_count_and_capture_test
	import timer16_pkg::*;
;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	io_req_t io_req;
	logic [7:0] io_rdata;
	presc_t presc_tick = '0;
	logic ext_tick_pin = 1'b0;
	logic capture_pin = 1'b0;
	logic comparator_output = 1'b0;
	logic comparator_capture_select = 1'b0;
	logic capture_irq_ack = 1'b0;
	logic overflow_irq_ack = 1'b0;
	logic capture_irq, overflow_irq, count_at_top, count_at_bottom;
	logic [15:0] timer_count;
	int bad_count = 0;
	int cmp_count = 0;

	always #2.5 mclk = ~mclk;

	timer16_count_and_capture u_timer16_count_and_capture (.mclk, .rst_n,
		.io_req, .io_rdata, .presc_tick, .ext_tick_pin, .capture_pin,
		.comparator_output, .comparator_capture_select, .capture_irq_ack,
		.overflow_irq_ack, .capture_irq, .overflow_irq, .timer_count,
		.count_at_top, .count_at_bottom);
	cpu_model u_cpu_model (.mclk, .io_req, .io_rdata);

	task automatic close_out;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] s,
		input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic w16(input logic [3:0] lo, input logic [15:0] v);
		u_cpu_model.wr(lo + 4'h1, v[15:8]);
		u_cpu_model.wr(lo, v[7:0]);
	endtask

	task automatic r16(input logic [3:0] lo, output logic [15:0] v);
		u_cpu_model.rd(lo, v[7:0]);
		u_cpu_model.rd(lo + 4'h1, v[15:8]);
	endtask

	task automatic setup(input logic [3:0] m, input logic [2:0] c,
		input logic [1:0] nr);
		u_cpu_model.wr(SEL_CTRL_A, {6'h00, m[1:0]});
		u_cpu_model.wr(SEL_CTRL_B, {nr, 1'b0, m[3:2], c});
	endtask

	task automatic wait_cyc(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask

	task automatic lat(input logic [1:0] nr, output int n);
		setup(WGM_NORMAL, CS_STOP, nr);
		u_cpu_model.wr(SEL_FLAGS, 8'h20);
		if (comparator_capture_select)
			comparator_output = ~comparator_output;
		else
			capture_pin = ~capture_pin;
		n = 0;
		while (capture_irq !== 1'b1 && n < 40) begin
			wait_cyc(1);
			n++;
		end
	endtask

	task automatic t_rw;
		logic [15:0] v;
		setup(WGM_NORMAL, CS_STOP, 2'b00);
		w16(SEL_CNT_L, 16'h01FF);
		chk("count", timer_count, 16'h01FF);
		r16(SEL_CNT_L, v);
		chk("count read", v, 16'h01FF);
		$display("t_rw done");
	endtask

	task automatic t_count;
		int n;
		u_cpu_model.wr(SEL_IRQ_EN, 8'h24);
		setup(WGM_NORMAL, CS_CLK, 2'b00);
		w16(SEL_CNT_L, 16'hFFF0);
		n = 0;
		while (overflow_irq !== 1'b1 && n < 40) begin
			wait_cyc(1);
			n++;
		end
		chk("wrap", timer_count, 16'h0000);
		chk("bottom", 16'(count_at_bottom), 16'h0001);
		setup(WGM_NORMAL, CS_STOP, 2'b00);
		overflow_irq_ack = 1'b1;
		wait_cyc(1);
		overflow_irq_ack = 1'b0;
		chk("overflow ack", 16'(overflow_irq), 16'h0000);
		$display("t_count done");
	endtask

	task automatic t_cap;
		int n0;
		int n1;
		logic [15:0] v;
		w16(SEL_CNT_L, 16'h1234);
		lat(2'b01, n0);
		r16(SEL_CAP_L, v);
		chk("capture", v, 16'h1234);
		u_cpu_model.wr(SEL_FLAGS, 8'h00);
		chk("flag kept", 16'(capture_irq), 16'h0001);
		lat(2'b10, n1);
		chk("filter delay", 16'(n1 - n0), 16'h0004);
		setup(WGM_NORMAL, CS_STOP, 2'b11);
		u_cpu_model.wr(SEL_FLAGS, 8'h20);
		capture_pin = 1'b1;
		wait_cyc(3);
		capture_pin = 1'b0;
		wait_cyc(15);
		chk("glitch", 16'(capture_irq), 16'h0000);
		lat(2'b01, n0);
		chk("rise", 16'(capture_irq), 16'h0001);
		capture_irq_ack = 1'b1;
		wait_cyc(1);
		capture_irq_ack = 1'b0;
		chk("ack", 16'(capture_irq), 16'h0000);
		comparator_capture_select = 1'b1;
		comparator_output = 1'b1;
		wait_cyc(2);
		capture_pin = 1'b0;
		wait_cyc(15);
		chk("pin ignored", 16'(capture_irq), 16'h0000);
		lat(2'b00, n0);
		chk("comparator", 16'(capture_irq), 16'h0001);
		comparator_capture_select = 1'b0;
		$display("t_cap done");
	endtask

	task automatic t_top;
		logic [15:0] v;
		logic [15:0] tops [3] = '{TOP_8BIT, TOP_9BIT, TOP_10BIT};
		for (int i = 0; i < 3; i++) begin
			setup(4'(i + 1), CS_STOP, 2'b00);
			w16(SEL_CNT_L, tops[i]);
			wait_cyc(1);
			chk("fixed top", 16'(count_at_top), 16'h0001);
		end
		setup(WGM_NORMAL, CS_STOP, 2'b00);
		wait_cyc(1);
		chk("no top", 16'(count_at_top), 16'h0000);
		w16(SEL_CAP_L, 16'hBEEF);
		r16(SEL_CAP_L, v);
		chk("cap locked", v, 16'h1234);
		setup(WGM_CTC_CAP, CS_STOP, 2'b00);
		w16(SEL_CAP_L, 16'h0345);
		capture_pin = 1'b1;
		wait_cyc(8);
		capture_pin = 1'b0;
		wait_cyc(8);
		r16(SEL_CAP_L, v);
		chk("cap top", v, 16'h0345);
		w16(SEL_CNT_L, 16'h0345);
		wait_cyc(1);
		chk("cap at top", 16'(count_at_top), 16'h0001);
		$display("t_top done");
	endtask

	task automatic t_src;
		setup(WGM_NORMAL, CS_DIV8, 2'b00);
		w16(SEL_CNT_L, 16'h0010);
		presc_tick.div8 = 1'b1;
		wait_cyc(1);
		presc_tick.div8 = 1'b0;
		wait_cyc(3);
		chk("tap tick", timer_count, 16'h0011);
		setup(WGM_NORMAL, CS_EXT_RISE, 2'b00);
		ext_tick_pin = 1'b1;
		wait_cyc(3);
		ext_tick_pin = 1'b0;
		wait_cyc(3);
		chk("pin tick", timer_count, 16'h0012);
		setup(WGM_PC8, CS_CLK, 2'b00);
		w16(SEL_CNT_L, 16'h00FD);
		wait_cyc(2);
		chk("turn top", 16'(count_at_top), 16'h0001);
		wait_cyc(2);
		chk("count down", timer_count, 16'h00FD);
		setup(WGM_NORMAL, CS_STOP, 2'b00);
		$display("t_src done");
	endtask

	initial begin
		repeat (16) @(posedge mclk);
		#1 rst_n = 1'b1;
		t_rw();
		t_count();
		t_cap();
		t_top();
		t_src();
		close_out();
	end

	initial begin
		repeat (5000) @(posedge mclk);
		bad_count++;
		close_out();
	end
endmodule
`default_nettype wire

// File: timer16_pkg.sv
// Purpose: shared constants and types of the 16-bit timer counter block
// Assumes: 8-bit I/O bus, byte-wide register selects of our own
// Notes: registers are reached by select code on the I/O port
package timer16_pkg;

	// Register select codes on the I/O port
	localparam logic [3:0] SEL_CTRL_A = 4'h0;
	localparam logic [3:0] SEL_CTRL_B = 4'h1;
	localparam logic [3:0] SEL_CNT_L = 4'h2;
	localparam logic [3:0] SEL_CNT_H = 4'h3;
	localparam logic [3:0] SEL_CAP_L = 4'h4;
	localparam logic [3:0] SEL_CAP_H = 4'h5;
	localparam logic [3:0] SEL_CMPA_L = 4'h6;
	localparam logic [3:0] SEL_CMPA_H = 4'h7;
	localparam logic [3:0] SEL_FLAGS = 4'h8;
	localparam logic [3:0] SEL_IRQ_EN = 4'h9;

	// Field positions
	localparam int B_NF_EN = 7;
	localparam int B_EDGE_RISE = 6;
	localparam int B_WGM_HI = 3;
	localparam int B_CAP_FLAG = 5;
	localparam int B_OVF_FLAG = 2;

	// Clock source selector codes
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_CLK = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;

	// Waveform modes
	localparam logic [3:0] WGM_NORMAL = 4'h0;
	localparam logic [3:0] WGM_PC8 = 4'h1;
	localparam logic [3:0] WGM_PC9 = 4'h2;
	localparam logic [3:0] WGM_PC10 = 4'h3;
	localparam logic [3:0] WGM_CTC_A = 4'h4;
	localparam logic [3:0] WGM_FAST8 = 4'h5;
	localparam logic [3:0] WGM_FAST9 = 4'h6;
	localparam logic [3:0] WGM_FAST10 = 4'h7;
	localparam logic [3:0] WGM_PFC_CAP = 4'h8;
	localparam logic [3:0] WGM_PFC_A = 4'h9;
	localparam logic [3:0] WGM_PC_CAP = 4'hA;
	localparam logic [3:0] WGM_PC_A = 4'hB;
	localparam logic [3:0] WGM_CTC_CAP = 4'hC;
	localparam logic [3:0] WGM_FAST_CAP = 4'hE;
	localparam logic [3:0] WGM_FAST_A = 4'hF;

	// Counter values
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_BOTTOM = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;

	// Noise filter sample count
	localparam int FILT_SAMPLES = 4;

	typedef enum logic [1:0] {
		DIR_UP = 2'b01,
		DIR_DOWN = 2'b10
	} dir_t;

	typedef struct packed {
		logic [3:0] sel;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} io_req_t;

	typedef struct packed {
		logic div8;
		logic div64;
		logic div256;
		logic div1024;
	} presc_t;

	typedef struct packed {
		logic [1:0] wgm_lo;
		logic [7:0] ctrl_b;
		logic [15:0] cnt;
		logic [15:0] cap;
		logic [15:0] cmpa;
		logic [7:0] temp;
		dir_t dir;
		logic cap_flag;
		logic ovf_flag;
		logic cap_ie;
		logic ovf_ie;
		logic ext_prev;
		logic in_smp;
		logic [FILT_SAMPLES-1:0] filt_sh;
		logic filt_out;
		logic edge_prev;
		logic [7:0] rdata;
		logic cap_irq;
		logic ovf_irq;
		logic at_top;
		logic at_bottom;
	} state_t;

endpackage
